// *** pcrs_cpu_model.sv ***
`timescale 1ns/10ps
module pcrs_cpu_model (
   input wire logic reset_lock_out,
   input wire logic reset_lock_oe,
   output logic cpu_reset_line
);
   // Pull-up wins whenever the device lets go of the line
   assign cpu_reset_line = reset_lock_oe ? reset_lock_out : 1'b1;
endmodule : pcrs_cpu_model

// *** pcrs_phase_div.sv ***
`timescale 1ns/10ps
module pcrs_phase_div (
   input wire logic clk,
   input wire logic srst,
   output logic [2:0] phase,
   output logic base_tick
);
   logic [2:0] ph_q;
   logic [2:0] ph_d;

   // Free-running phase, never gated
   always_comb begin
      ph_d = ph_q + 3'h1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ph_q <= pcrs_pkg::PH_RESET;
      end else begin
         ph_q <= ph_d;
      end
   end

   // One pulse per base clock period
   assign phase = ph_q;
   assign base_tick = (ph_q[1:0] == pcrs_pkg::PH_BASE_LAST);
endmodule : pcrs_phase_div

// *** pcrs_pkg.sv ***
package pcrs_pkg;
   // Clock and request timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int REQ_MIN_LOW_NS = 10;
   localparam int REQ_MIN_LOW_CYC_RAW =
      (REQ_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_MIN_LOW_CYC =
      (REQ_MIN_LOW_CYC_RAW < 1) ? 1 : REQ_MIN_LOW_CYC_RAW;

   // Reset interval in base clock cycles and reference cycles
   localparam int CNT_W = 11;
   localparam logic [10:0] RST_BASE_CYCLES = 11'h400;
   localparam int RST_REF_CYCLES = 512;
   localparam logic [10:0] CNT_RESET = 11'h000;

   // Output divider phase
   localparam int PH_W = 3;
   localparam logic [2:0] PH_RESET = 3'h0;
   localparam logic [1:0] PH_BASE_LAST = 2'h3;

   // Power-down recovery bound in base cycles
   localparam int PD_RECOVER_BASE = 3;

   // Bounds on one reset interval in clock cycles, for the helper check
   localparam int HOLD_MIN = 4092;
   localparam int HOLD_MAX = 4100;

   // Reset/lock output sequencer states
   typedef enum logic [1:0] {
      ST_UNLOCKED,
      ST_REQ_HELD,
      ST_COUNTING,
      ST_RELEASED
   } pcrs_state_t;
endpackage : pcrs_pkg

// *** pcrs_sequencer.sv ***
`timescale 1ns/10ps
// Function
// - Power-down holds double-rate, base a, b low
// - Held outputs rejoin in phase within three cycles
// - Request pulse holds reset/lock low 1024 base cycles
// - Clocks keep running during the reset interval
// - After 1024th cycle release reset/lock to high-Z
// - Request low at start-up keeps output low
// - Output released only after PLL lock
// - Unlocked with request high drives output low
// - Double-rate at twice base, half-rate at half
module pcrs_sequencer (
   input wire logic clk,
   input wire logic srst,
   input wire logic pll_locked,
   input wire logic output_powerdown_reset_n,
   input wire logic reset_request_n,
   output logic double_rate_clock_out,
   output logic base_clock_out_a,
   output logic base_clock_out_b,
   output logic base_clock_out_c,
   output logic inverted_base_clock_out,
   output logic half_rate_clock_out,
   output logic reset_lock_out,
   output logic reset_lock_oe
);
   logic [2:0] phase;
   logic base_tick;
   logic held_q, held_d;
   logic dbl_q, dbl_d;
   logic base_ab_q, base_ab_d;
   logic base_c_q, base_c_d;
   logic inv_q, inv_d;
   logic half_q, half_d;
   pcrs_pkg::pcrs_state_t state_q, state_d;
   logic [10:0] cnt_q, cnt_d;
   logic oe_q, oe_d;
   logic od_q;

   // Divider supplying phase and base-period enable
   pcrs_phase_div u_div (
      .clk(clk),
      .srst(srst),
      .phase(phase),
      .base_tick(base_tick)
   );

   // Power-down hold, cleared only on a base period boundary
   always_comb begin
      held_d = held_q;
      if (!output_powerdown_reset_n) begin
         held_d = 1'b1;
      end else if (base_tick) begin
         held_d = 1'b0;
      end
   end

   // Output clock waveforms from the shared phase
   always_comb begin
      dbl_d = ~phase[0] & ~held_d;
      base_ab_d = ~phase[1] & ~held_d;
      base_c_d = ~phase[1];
      inv_d = phase[1];
      half_d = ~phase[2];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         held_q <= 1'b1;
         dbl_q <= 1'b0;
         base_ab_q <= 1'b0;
         base_c_q <= 1'b0;
         inv_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         held_q <= held_d;
         dbl_q <= dbl_d;
         base_ab_q <= base_ab_d;
         base_c_q <= base_c_d;
         inv_q <= inv_d;
         half_q <= half_d;
      end
   end

   // Reset/lock sequencing; any sampled low request counts
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (!pll_locked) begin
         state_d = pcrs_pkg::ST_UNLOCKED;
         cnt_d = pcrs_pkg::CNT_RESET;
      end else if (!reset_request_n) begin
         state_d = pcrs_pkg::ST_REQ_HELD;
         cnt_d = pcrs_pkg::CNT_RESET;
      end else begin
         case (state_q)
            pcrs_pkg::ST_UNLOCKED: begin
               state_d = pcrs_pkg::ST_COUNTING;
            end
            pcrs_pkg::ST_REQ_HELD: begin
               state_d = pcrs_pkg::ST_COUNTING;
            end
            pcrs_pkg::ST_COUNTING: begin
               if (base_tick) begin
                  if (cnt_q == pcrs_pkg::RST_BASE_CYCLES - 11'h001) begin
                     state_d = pcrs_pkg::ST_RELEASED;
                     cnt_d = pcrs_pkg::CNT_RESET;
                  end else begin
                     cnt_d = cnt_q + 11'h001;
                  end
               end
            end
            pcrs_pkg::ST_RELEASED: begin
               state_d = pcrs_pkg::ST_RELEASED;
            end
            default: begin
               state_d = pcrs_pkg::ST_UNLOCKED;
            end
         endcase
      end
      oe_d = (state_d != pcrs_pkg::ST_RELEASED);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= pcrs_pkg::ST_UNLOCKED;
         cnt_q <= pcrs_pkg::CNT_RESET;
         oe_q <= 1'b1;
         od_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         oe_q <= oe_d;
         od_q <= 1'b0; // Open drain only ever pulls low
      end
   end

   assign double_rate_clock_out = dbl_q;
   assign base_clock_out_a = base_ab_q;
   assign base_clock_out_b = base_ab_q;
   assign base_clock_out_c = base_c_q;
   assign inverted_base_clock_out = inv_q;
   assign half_rate_clock_out = half_q;
   assign reset_lock_out = od_q;
   assign reset_lock_oe = oe_q;

   // Helper: clock cycles spent low with request high and locked
   logic [13:0] hold_cyc_q;
   always_ff @(posedge clk) begin
      if (srst || !reset_request_n || !pll_locked || !oe_q) begin
         hold_cyc_q <= 14'h0000;
      end else begin
         hold_cyc_q <= hold_cyc_q + 14'h0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_PD_HOLD: assert property (
      !output_powerdown_reset_n |=> !double_rate_clock_out
         && !base_clock_out_a && !base_clock_out_b)
      else $error("Held outputs not low in power-down");

   AST_OTHERS_RUN: assert property (
      $rose(base_clock_out_c) |-> ##4 $rose(base_clock_out_c))
      else $error("Free-running base output stopped");

   AST_PD_RECOVER: assert property (
      output_powerdown_reset_n [*6] |->
         base_clock_out_a == base_clock_out_c)
      else $error("Held output not back in phase");

   AST_REQ_LOW: assert property (
      (!reset_request_n && pll_locked) |=> reset_lock_oe
         && cnt_q == 11'h000)
      else $error("Request did not pull output low");

   AST_HOLD_LEN: assert property (
      $fell(reset_lock_oe) |->
         $past(hold_cyc_q) >= pcrs_pkg::HOLD_MIN
         && $past(hold_cyc_q) <= pcrs_pkg::HOLD_MAX)
      else $error("Reset interval length wrong");

   AST_UNLOCK_LOW: assert property (
      !pll_locked |=> reset_lock_oe && state_q == pcrs_pkg::ST_UNLOCKED)
      else $error("Output not low while unlocked");

   AST_START_HOLD: assert property (
      !reset_request_n [*2] |-> reset_lock_oe)
      else $error("Output released with request low");

   AST_LOCK_ONLY: assert property (
      !reset_lock_oe |-> $past(pll_locked))
      else $error("Output released without lock");

   AST_DBL_RATE: assert property (
      ($rose(double_rate_clock_out) && output_powerdown_reset_n)
         ##1 output_powerdown_reset_n
         |-> ##1 $rose(double_rate_clock_out))
      else $error("Double-rate period wrong");

   AST_HALF_RATE: assert property (
      $rose(half_rate_clock_out) |-> ##8 $rose(half_rate_clock_out))
      else $error("Half-rate period wrong");

   AST_DRIVE_LOW: assert property (
      reset_lock_oe |-> !reset_lock_out)
      else $error("Open drain driven high");

   COV_RESET_PULSE: cover property (
      $fell(reset_request_n) ##[1:8] $rose(reset_lock_oe));
   COV_PD_CYCLE: cover property (
      $fell(output_powerdown_reset_n) ##[1:40]
         $rose(base_clock_out_a));
   COV_LOCK_RELEASE: cover property (
      $rose(pll_locked) ##1 reset_request_n [*8]);
endmodule : pcrs_sequencer

// *** tb_pll_clock_reset_sequencer.sv ***
`timescale 1ns/10ps
module tb_pll_clock_reset_sequencer;
   logic clk, srst, lock, pd_n, req_n;
   logic dbl, qa, qb, qc, qi, half, rl_out, rl_oe, line;
   int bad_count = 0;
   int n_compared = 0;
   pcrs_sequencer i_dut (.clk(clk), .srst(srst), .pll_locked(lock),
      .output_powerdown_reset_n(pd_n), .reset_request_n(req_n),
      .double_rate_clock_out(dbl), .base_clock_out_a(qa),
      .base_clock_out_b(qb), .base_clock_out_c(qc),
      .inverted_base_clock_out(qi), .half_rate_clock_out(half),
      .reset_lock_out(rl_out), .reset_lock_oe(rl_oe));
   pcrs_cpu_model i_cpu (.reset_lock_out(rl_out), .reset_lock_oe(rl_oe),
      .cpu_reset_line(line));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string what, input logic seen, input logic exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", what, exp, seen);
      end
   endtask : check
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Counts cycles until the line rises, n0 already gone
   task automatic wait_rel(input string what, input int n0);
      int n;
      n = n0;
      while (line !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      check(what, n >= 4090 && n <= 4100, 1'b1);
   endtask : wait_rel
   // Watches 16 cycles of every clock output
   task automatic run_clocks(input logic held);
      logic [3:0] now, prev;
      int cnt [4];
      cnt = '{0, 0, 0, 0};
      prev = {dbl, qc, half, qa};
      repeat (16) begin
         @(negedge clk);
         now = {dbl, qc, half, qa};
         for (int i = 0; i < 4; i++) cnt[i] += int'(now[i] != prev[i]);
         prev = now;
         check("inverted", qi, ~qc);
         check("base a", qa, held ? 1'b0 : qc);
         check("base b", qb, held ? 1'b0 : qc);
      end
      check("dbl rate", cnt[3] == (held ? 0 : 16), 1'b1);
      check("base rate", cnt[2] == 8, 1'b1);
      check("half rate", cnt[1] == 4, 1'b1);
   endtask : run_clocks
   task automatic pulse;
      @(negedge clk);
      req_n = 1'b0;
      repeat (2) @(negedge clk);
      req_n = 1'b1;
      check("line on request", line, 1'b0);
   endtask : pulse
   task automatic t_unlocked;
      // Held outputs rejoin only at the first base tick after reset
      repeat (4) @(negedge clk);
      run_clocks(1'b0);
      check("unlocked line", line, 1'b0);
      lock = 1'b1;
      wait_rel("lock release", 0);
      $display("test unlocked done");
   endtask : t_unlocked
   task automatic t_request;
      pulse();
      run_clocks(1'b0);
      check("held line", line, 1'b0);
      wait_rel("request release", 16);
      $display("test request done");
   endtask : t_request
   task automatic t_restart;
      pulse();
      repeat (2000) @(negedge clk);
      pulse();
      wait_rel("restart release", 0);
      $display("test restart done");
   endtask : t_restart
   task automatic t_start_low;
      srst = 1'b1;
      req_n = 1'b0;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      repeat (100) @(negedge clk);
      check("start low line", line, 1'b0);
      req_n = 1'b1;
      wait_rel("start release", 0);
      $display("test start low done");
   endtask : t_start_low
   task automatic t_powerdown;
      pd_n = 1'b0;
      repeat (2) @(negedge clk);
      run_clocks(1'b1);
      pd_n = 1'b1;
      repeat (5) @(negedge clk);
      run_clocks(1'b0);
      $display("test power-down done");
   endtask : t_powerdown
   // Watchdog
   initial begin
      repeat (25000) @(posedge clk);
      bad_count++;
      $display("timeout");
      final_report();
   end
   // Main sequence
   initial begin
      srst = 1'b1;
      lock = 1'b0;
      pd_n = 1'b1;
      req_n = 1'b1;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      t_unlocked();
      t_request();
      t_restart();
      t_powerdown();
      t_start_low();
      final_report();
   end
endmodule : tb_pll_clock_reset_sequencer
